// ---- core/bcf_map.svh ----
// constants for the branch, call and flow unit: opcodes, reset values, cycle lengths
`ifndef BCF_MAP_SVH
`define BCF_MAP_SVH

// opcodes handled by this unit
`define BCF_OP_BRANCH_NOT_NULL 8'h20
`define BCF_OP_LOOP            8'h10
`define BCF_OP_JUMP_POINTER    8'hE9
`define BCF_OP_PREFIX_FIRST    8'hDD
`define BCF_OP_PREFIX_SECOND   8'hFD
`define BCF_OP_CALL            8'hCD

// reset values
`define BCF_PC_RESET           16'h0000
`define BCF_SP_RESET           16'hFFFF
`define BCF_COUNT_RESET        8'h00

// machine cycle lengths in clock periods
`define BCF_LEN_FETCH          3'h4
`define BCF_LEN_LOOP_EXTRA     3'h1
`define BCF_LEN_READ           3'h3
`define BCF_LEN_READ_LONG      3'h4
`define BCF_LEN_WRITE          3'h3
`define BCF_LEN_BRANCH         3'h5

`endif

// ---- core/bcf_pkg.sv ----
// types shared by the branch, call and flow unit
package bcf_pkg;

    // machine cycle being run
    typedef enum logic [3:0] {
        ST_FETCH     = 4'b0000,
        ST_PFX_FETCH = 4'b0001,
        ST_LOOP_DEC  = 4'b0010,
        ST_DISP_READ = 4'b0011,
        ST_BRANCH    = 4'b0100,
        ST_ADDR_LO   = 4'b0101,
        ST_ADDR_HI   = 4'b0110,
        ST_PUSH_HI   = 4'b0111,
        ST_PUSH_LO   = 4'b1000
    } bcf_state_t;

    // request toward external memory
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
        logic        fetch;
    } bcf_mem_req_t;

    // pointer registers supplied by the core
    typedef struct packed {
        logic [15:0] primary_pointer_pair;
        logic [15:0] first_index_register;
        logic [15:0] second_index_register;
    } bcf_core_regs_t;

endpackage

// ---- core/bcf_flow_unit.sv ----
// program-flow unit: relative branch, pointer jumps, loop branch and call
//
// Notes on behaviour
// RULE_01 - null flag clear: add signed displacement to counter, fetch from there
// RULE_02 - targets reckoned from branch opcode address, span -126 to +129
// RULE_03 - null flag set: branch not taken, continue after the two bytes
// RULE_04 - taken branch: three machine cycles of 4, 3, 5 clocks
// RULE_05 - untaken branch: two machine cycles of 4 and 3 clocks
// RULE_06 - displacement byte is two's complement, applied after both bytes fetched
// RULE_07 - E9 copies primary pointer pair into counter in 4 clocks
// RULE_08 - DD then E9 loads counter from first index register, 4 plus 4
// RULE_09 - FD then E9 loads counter from second index register, 4 plus 4
// RULE_10 - opcode 10 decrements loop count; nonzero branches in 5, 3, 5 clocks
// RULE_11 - loop count reaching zero falls through after 5 and 3 clocks
// RULE_12 - call is CD then target low byte then high byte
// RULE_13 - call pushes high then low byte below stack pointer, then jumps
// RULE_14 - pushed return address points past the three call bytes
// RULE_15 - none of these instructions alter any flag bit
// RULE_16 - memory must store both pushed bytes at the driven address
`timescale 1ns/1ps
`default_nettype none
`include "bcf_map.svh"

module bcf_flow_unit (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // external memory
    output var bcf_pkg::bcf_mem_req_t   mem_req,
    input  wire logic [7:0]             mem_rdata,
    // core register values
    input  wire bcf_pkg::bcf_core_regs_t core_regs,
    input  wire logic [7:0]             flags_in,
    input  wire logic                   null_flag,
    // core loads of stack pointer and loop count
    input  wire logic                   sp_load,
    input  wire logic [15:0]            sp_value,
    input  wire logic                   count_load,
    input  wire logic [7:0]             count_value,
    // state toward the core
    output logic [15:0]                 program_counter,
    output logic [15:0]                 stack_pointer,
    output logic [7:0]                  loop_count,
    output logic [7:0]                  flags_out,
    output logic                        instr_done,
    output logic                        unsupported
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    bcf_pkg::bcf_state_t state;
    bcf_pkg::bcf_state_t next_state;
    logic [2:0]          tcnt;
    logic [2:0]          cycle_len;
    logic                advance;
    logic [15:0]         next_pc;
    logic [15:0]         next_sp;
    logic [7:0]          opcode;
    logic                prefix_second;
    logic [7:0]          disp;
    logic [7:0]          target_lo;
    logic [7:0]          target_hi;
    logic                branch_taken;
    logic                next_unsupported;

    // machine cycle sequences, clocks per cycle in brackets:
    //   relative branch  fetch(4) read(3), then internal(5) only when taken
    //   loop branch      fetch(4) internal(1) read(3), then internal(5) when taken
    //   pointer jump     fetch(4)
    //   index jump       fetch(4) fetch(4), the first byte picks the register
    //   call             fetch(4) read lo(3) read hi(4) write hi(3) write lo(3)
    //   anything else    fetch(4), or fetch(4) fetch(4) after a prefix, flagged unsupported and stepped over
    // memory has no wait input, so every length is fixed and a cycle ends on
    // the edge where tcnt, already at its length minus one, returns to zero

    ////////////////////////////////////////////////////////////////////////////
    // machine cycle length per state
    // writes share the default length; unused codes fall back to it too
    always_comb begin
        case (state)
            bcf_pkg::ST_FETCH:     cycle_len = `BCF_LEN_FETCH;      // [RULE_07]
            bcf_pkg::ST_PFX_FETCH: cycle_len = `BCF_LEN_FETCH;      // [RULE_08] [RULE_09]
            bcf_pkg::ST_LOOP_DEC:  cycle_len = `BCF_LEN_LOOP_EXTRA; // [RULE_10] [RULE_11]
            bcf_pkg::ST_DISP_READ: cycle_len = `BCF_LEN_READ;       // [RULE_05]
            bcf_pkg::ST_BRANCH:    cycle_len = `BCF_LEN_BRANCH;     // [RULE_04]
            bcf_pkg::ST_ADDR_LO:   cycle_len = `BCF_LEN_READ;
            bcf_pkg::ST_ADDR_HI:   cycle_len = `BCF_LEN_READ_LONG;  // [RULE_13]
            default:               cycle_len = `BCF_LEN_WRITE;
        endcase
    end

    assign advance = (tcnt == 3'(cycle_len - 3'h1));

    // taken test; loop count is already decremented when the displacement lands
    assign branch_taken = (opcode == `BCF_OP_BRANCH_NOT_NULL) ? !null_flag // [RULE_01] [RULE_03]
                                                              : (loop_count != 8'h00); // [RULE_10] [RULE_11]

    ////////////////////////////////////////////////////////////////////////////
    // sequencing of machine cycles and counter arithmetic
    always_comb begin
        next_state       = state;
        next_pc          = program_counter;
        next_sp          = stack_pointer;
        next_unsupported = 1'b0;
        if (advance) begin
            case (state)
                bcf_pkg::ST_FETCH: begin
                    next_pc = program_counter + 16'h0001;
                    if (mem_rdata == `BCF_OP_JUMP_POINTER) begin
                        next_pc = core_regs.primary_pointer_pair; // [RULE_07]
                    end else if (mem_rdata == `BCF_OP_PREFIX_FIRST ||
                                 mem_rdata == `BCF_OP_PREFIX_SECOND) begin
                        next_state = bcf_pkg::ST_PFX_FETCH;
                    end else if (mem_rdata == `BCF_OP_BRANCH_NOT_NULL) begin
                        next_state = bcf_pkg::ST_DISP_READ;
                    end else if (mem_rdata == `BCF_OP_LOOP) begin
                        next_state = bcf_pkg::ST_LOOP_DEC; // fifth clock of the fetch [RULE_10]
                    end else if (mem_rdata == `BCF_OP_CALL) begin
                        next_state = bcf_pkg::ST_ADDR_LO; // [RULE_12]
                    end else begin
                        next_unsupported = 1'b1;
                    end
                end
                bcf_pkg::ST_PFX_FETCH: begin
                    next_state = bcf_pkg::ST_FETCH;
                    next_pc    = program_counter + 16'h0001;
                    if (mem_rdata == `BCF_OP_JUMP_POINTER) begin
                        next_pc = prefix_second ? core_regs.second_index_register  // [RULE_09]
                                                : core_regs.first_index_register;  // [RULE_08]
                    end else begin
                        next_unsupported = 1'b1;
                    end
                end
                bcf_pkg::ST_LOOP_DEC: begin
                    next_state = bcf_pkg::ST_DISP_READ;
                end
                bcf_pkg::ST_DISP_READ: begin
                    // counter now sits past both bytes [RULE_06]
                    next_pc    = program_counter + 16'h0001;
                    next_state = branch_taken ? bcf_pkg::ST_BRANCH : bcf_pkg::ST_FETCH; // [RULE_03] [RULE_05] [RULE_11]
                end
                bcf_pkg::ST_BRANCH: begin
                    // base is opcode address plus two, so the span is -126..+129
                    next_pc    = program_counter + {{8{disp[7]}}, disp}; // [RULE_01] [RULE_02] [RULE_06]
                    next_state = bcf_pkg::ST_FETCH;
                end
                bcf_pkg::ST_ADDR_LO: begin
                    next_pc    = program_counter + 16'h0001;
                    next_state = bcf_pkg::ST_ADDR_HI;
                end
                bcf_pkg::ST_ADDR_HI: begin
                    // return address is past all three call bytes [RULE_14]
                    next_pc    = program_counter + 16'h0001;
                    next_sp    = stack_pointer - 16'h0001; // [RULE_13]
                    next_state = bcf_pkg::ST_PUSH_HI;
                end
                bcf_pkg::ST_PUSH_HI: begin
                    next_sp    = stack_pointer - 16'h0001; // [RULE_13]
                    next_state = bcf_pkg::ST_PUSH_LO;
                end
                bcf_pkg::ST_PUSH_LO: begin
                    next_pc    = {target_hi, target_lo}; // [RULE_12] [RULE_13]
                    next_state = bcf_pkg::ST_FETCH;
                end
                default: begin
                    next_state = bcf_pkg::ST_FETCH;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state and clock-period counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= bcf_pkg::ST_FETCH;
            tcnt  <= 3'h0;
        end else begin
            state <= next_state;
            tcnt  <= advance ? 3'h0 : 3'(tcnt + 3'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter and stack pointer; own updates win over core loads
    // a core load that lands while a call is decrementing is lost, so the core
    // must not load the stack pointer during a call
    always_ff @(posedge mclk) begin
        if (rst) begin
            program_counter <= `BCF_PC_RESET;
            stack_pointer   <= `BCF_SP_RESET;
        end else begin
            program_counter <= next_pc;
            if (next_sp != stack_pointer) begin
                stack_pointer <= next_sp;
            end else if (sp_load) begin
                stack_pointer <= sp_value;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // loop count: decrement during the extra fetch clock
    // the taken test reads the decremented value one read cycle later, so a
    // start value of one falls straight through
    always_ff @(posedge mclk) begin
        if (rst) begin
            loop_count <= `BCF_COUNT_RESET;
        end else if (state == bcf_pkg::ST_LOOP_DEC) begin
            loop_count <= loop_count - 8'h01; // [RULE_10] [RULE_11]
        end else if (count_load) begin
            loop_count <= count_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operand capture at the last clock of each read
    // opcode stays put through the operand reads, so the taken test and the
    // push data never see a half-loaded instruction
    always_ff @(posedge mclk) begin
        if (rst) begin
            opcode        <= 8'h00;
            prefix_second <= 1'b0;
            disp          <= 8'h00;
            target_lo     <= 8'h00;
            target_hi     <= 8'h00;
        end else if (advance) begin
            if (state == bcf_pkg::ST_FETCH) begin
                opcode        <= mem_rdata;
                prefix_second <= (mem_rdata == `BCF_OP_PREFIX_SECOND);
            end
            if (state == bcf_pkg::ST_DISP_READ) begin
                disp <= mem_rdata; // [RULE_06]
            end
            if (state == bcf_pkg::ST_ADDR_LO) begin
                target_lo <= mem_rdata; // low byte first [RULE_12]
            end
            if (state == bcf_pkg::ST_ADDR_HI) begin
                target_hi <= mem_rdata; // [RULE_12]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory request, set up as each machine cycle begins so it stands registered
    // registering the request keeps address and strobes glitch-free for a whole
    // machine cycle, at the cost of working from next_state and next_pc
    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_req.addr  <= `BCF_PC_RESET;
            mem_req.wdata <= 8'h00;
            mem_req.rd    <= 1'b1;
            mem_req.wr    <= 1'b0;
            mem_req.fetch <= 1'b1;
        end else if (advance) begin
            mem_req.rd    <= 1'b0;
            mem_req.wr    <= 1'b0;
            mem_req.fetch <= 1'b0;
            case (next_state)
                bcf_pkg::ST_FETCH, bcf_pkg::ST_PFX_FETCH: begin
                    mem_req.addr  <= next_pc; // [RULE_01] [RULE_07]
                    mem_req.rd    <= 1'b1;
                    mem_req.fetch <= 1'b1;
                end
                bcf_pkg::ST_DISP_READ, bcf_pkg::ST_ADDR_LO, bcf_pkg::ST_ADDR_HI: begin
                    mem_req.addr <= next_pc;
                    mem_req.rd   <= 1'b1;
                end
                bcf_pkg::ST_PUSH_HI: begin
                    mem_req.addr  <= next_sp;
                    mem_req.wdata <= next_pc[15:8]; // program_counter_high_byte [RULE_13] [RULE_16]
                    mem_req.wr    <= 1'b1;
                end
                bcf_pkg::ST_PUSH_LO: begin
                    mem_req.addr  <= next_sp;
                    mem_req.wdata <= program_counter[7:0]; // program_counter_low_byte [RULE_13]
                    mem_req.wr    <= 1'b1;
                end
                default: begin
                    // internal cycles keep the bus quiet
                    mem_req.addr <= mem_req.addr;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status toward the core; flags pass through untouched
    // each pulse rises with the first clock of the following fetch, so the
    // core sees it once per instruction
    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_out   <= 8'h00;
            instr_done  <= 1'b0;
            unsupported <= 1'b0;
        end else begin
            flags_out   <= flags_in; // [RULE_15]
            instr_done  <= advance && (next_state == bcf_pkg::ST_FETCH);
            unsupported <= next_unsupported;
        end
    end

endmodule
`default_nettype wire

// ---- testbench/bcf_flow_unit_asserts.sv ----
// port checker for the program-flow unit, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module bcf_flow_unit_asserts (
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    rst,
    // external memory
    input wire bcf_pkg::bcf_mem_req_t   mem_req,
    input wire logic [7:0]              mem_rdata,
    // core side inputs
    input wire bcf_pkg::bcf_core_regs_t core_regs,
    input wire logic [7:0]              flags_in,
    input wire logic                    null_flag,
    input wire logic                    sp_load,
    input wire logic [15:0]             sp_value,
    input wire logic                    count_load,
    input wire logic [7:0]              count_value,
    // core side outputs
    input wire logic [15:0]             program_counter,
    input wire logic [15:0]             stack_pointer,
    input wire logic [7:0]              loop_count,
    input wire logic [7:0]              flags_out,
    input wire logic                    instr_done,
    input wire logic                    unsupported
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [15:0] op_addr;
    logic [15:0] ret_addr;
    // opcode address survives the push cycles because fetch is low there
    always_ff @(posedge mclk) begin
        if (mem_req.fetch) begin
            op_addr <= mem_req.addr;
        end
    end
    assign ret_addr = op_addr + 16'h0003;
    ////////////////////////////////////////////////////////////////////////
    AST_FLAGS: assert property (!$past(rst) |-> flags_out == $past(flags_in))
        else $error("flag register altered");
    AST_FETCH_LEN: assert property ($rose(mem_req.fetch) |-> mem_req.fetch [*4])
        else $error("fetch cycle shorter than four clocks");
    AST_DONE: assert property (
        instr_done |-> (mem_req.fetch && mem_req.rd && !mem_req.wr) ##1 !instr_done [*3])
        else $error("done pulse outside a fetch");
    AST_BRANCH_IDLE: assert property (
        $fell(mem_req.rd) && !mem_req.wr && !$past(mem_req.fetch)
        |-> (!mem_req.rd && !mem_req.wr) [*5] ##1 (mem_req.fetch && instr_done))
        else $error("branch internal cycle not five idle clocks");
    AST_LOOP_EXTRA: assert property (
        $fell(mem_req.rd) && !mem_req.wr && $past(mem_req.fetch)
        |-> ##1 (mem_req.rd && !mem_req.fetch) [*3])
        else $error("loop extra clock not followed by a three clock read");
    AST_PUSH_ORDER: assert property (
        $rose(mem_req.wr) |-> ##3 (mem_req.wr
        && mem_req.addr == $past(mem_req.addr, 3) - 16'h0001) ##3 !mem_req.wr)
        else $error("push writes misplaced");
    AST_PUSH_DATA: assert property (
        $rose(mem_req.wr) |-> mem_req.wdata == ret_addr[15:8]
        ##3 mem_req.wdata == ret_addr[7:0])
        else $error("pushed return address wrong");
    AST_SP_FINAL: assert property (
        $fell(mem_req.wr) |-> ##1 stack_pointer == $past(mem_req.addr, 2))
        else $error("stack pointer not at last pushed byte");
endmodule
bind bcf_flow_unit bcf_flow_unit_asserts u_asserts (.mclk(mclk), .rst(rst),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .core_regs(core_regs), .flags_in(flags_in),
    .null_flag(null_flag), .sp_load(sp_load), .sp_value(sp_value),
    .count_load(count_load), .count_value(count_value), .program_counter(program_counter),
    .stack_pointer(stack_pointer), .loop_count(loop_count), .flags_out(flags_out),
    .instr_done(instr_done), .unsupported(unsupported));
`default_nettype wire

// ---- testbench/bcf_mem_model.sv ----
// behavioural program and stack memory on the processor bus
`timescale 1ns/1ps
`default_nettype none
module bcf_mem_model (
    // clock
    input  wire logic                  mclk,
    // processor bus
    input  wire bcf_pkg::bcf_mem_req_t mem_req,
    output logic [7:0]                 mem_rdata
);
    logic [7:0] store [0:65535];
    logic [7:0] last_rdata = 8'hC3;
    // off the bus the data lines show the inverse, so stale bytes never pass
    assign mem_rdata = mem_req.rd ? store[mem_req.addr] : ~last_rdata;
    // every write clock lands the byte at the driven address
    always @(posedge mclk) begin
        if (mem_req.rd) begin
            last_rdata <= mem_rdata;
        end
        if (mem_req.wr) begin
            store[mem_req.addr] <= mem_req.wdata;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench running a short program through the flow unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                    mclk, rst, null_flag, sp_load, count_load, instr_done, unsupported;
    logic [7:0]              flags_in, count_value, mem_rdata, loop_count, flags_out;
    logic [15:0]             sp_value, program_counter, stack_pointer;
    bcf_pkg::bcf_mem_req_t   mem_req;
    bcf_pkg::bcf_core_regs_t core_regs;
    int                      fail_count = 0;
    int                      comparisons = 0;
    int                      cycles = 0;

    bcf_flow_unit DUT (.mclk(mclk), .rst(rst), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .core_regs(core_regs), .flags_in(flags_in), .null_flag(null_flag),
        .sp_load(sp_load), .sp_value(sp_value), .count_load(count_load),
        .count_value(count_value), .program_counter(program_counter),
        .stack_pointer(stack_pointer), .loop_count(loop_count), .flags_out(flags_out),
        .instr_done(instr_done), .unsupported(unsupported));
    bcf_mem_model mem (.mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put2(input logic [15:0] a, input logic [7:0] b0, input logic [7:0] b1);
        mem.store[a] = b0;
        mem.store[a + 16'h0001] = b1;
    endtask
    // runs one instruction; flags move every clock so any flag change shows
    task automatic step(input logic nf, input logic [15:0] exp_addr, input int exp_len);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            null_flag <= nf;
            flags_in <= flags_in + 8'h11;
            #1;
            n++;
        end while (instr_done !== 1'b1 && n < 40);
        chk("instruction done", 16'h0001, {15'h0000, instr_done});
        chk("next fetch address", exp_addr, mem_req.addr);
        chk("program counter", exp_addr, program_counter);
        chk("flags out", {8'h00, flags_in - 8'h11}, {8'h00, flags_out});
        if (exp_len > 0) begin
            chk("instruction clocks", 16'(exp_len), 16'(n));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_pointer_jump();
        step(1'b0, 16'h0480, 0);
        $display("test pointer jump done");
    endtask
    task automatic t_branch();
        step(1'b0, 16'h047C, 12);
        step(1'b1, 16'h047E, 7);
        $display("test relative branch done");
    endtask
    task automatic t_index_jumps();
        step(1'b0, 16'h0600, 8);
        step(1'b0, 16'h1A47, 8);
        $display("test index jumps done");
    endtask
    task automatic t_call();
        step(1'b0, 16'h2135, 17);
        chk("pushed high byte", 16'h001A, {8'h00, mem.store[16'h3001]});
        chk("pushed low byte", 16'h004A, {8'h00, mem.store[16'h3000]});
        $display("test call done");
    endtask
    task automatic t_loop();
        step(1'b0, 16'h2135, 13);
        chk("stack pointer after call", 16'h3000, stack_pointer);
        chk("loop count after first pass", 16'h0001, {8'h00, loop_count});
        step(1'b0, 16'h2137, 8);
        chk("loop count at exit", 16'h0000, {8'h00, loop_count});
        $display("test loop branch done");
    endtask
    task automatic t_span();
        step(1'b0, 16'h21B8, 12);
        step(1'b0, 16'h213A, 12);
        $display("test branch span done");
    endtask
    // unhandled bytes are stepped over with a one-cycle unsupported pulse
    task automatic t_unhandled();
        step(1'b0, 16'h213B, 4); // unhandled opcode skipped
        chk("unsupported pulse", 16'h0001, {15'h0000, unsupported}); // unhandled opcode
        step(1'b0, 16'h213D, 8); // unhandled byte after prefix
        chk("unsupported after prefix", 16'h0001, {15'h0000, unsupported}); // after prefix
        step(1'b0, 16'h0480, 4);
        chk("unsupported cleared", 16'h0000, {15'h0000, unsupported});
        $display("test unhandled opcodes done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // hang guard far above the program's run of under 150 clocks
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // program image, reset and scenario order
    initial begin
        rst = 1'b1;
        null_flag = 1'b0;
        sp_load = 1'b0;
        count_load = 1'b0;
        flags_in = 8'h5A;
        count_value = 8'h02;
        sp_value = 16'h3002;
        core_regs = '{16'h0480, 16'h0600, 16'h1A47};
        put2(16'h0000, 8'hE9, 8'h00);
        put2(16'h0480, 8'h20, 8'hFA);
        put2(16'h047C, 8'h20, 8'h05);
        put2(16'h047E, 8'hDD, 8'hE9);
        put2(16'h0600, 8'hFD, 8'hE9);
        put2(16'h1A47, 8'hCD, 8'h35);
        put2(16'h1A49, 8'h21, 8'h00);
        put2(16'h2135, 8'h10, 8'hFE);
        put2(16'h2137, 8'h20, 8'h7F);
        put2(16'h21B8, 8'h20, 8'h80);
        put2(16'h213A, 8'h00, 8'hDD);
        put2(16'h213C, 8'h00, 8'hE9);
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        sp_load <= 1'b1;
        count_load <= 1'b1;
        @(posedge mclk);
        sp_load <= 1'b0;
        count_load <= 1'b0;
        t_pointer_jump();
        t_branch();
        t_index_jumps();
        t_call();
        t_loop();
        t_span();
        t_unhandled();
        tally_and_finish();
    end
endmodule
`default_nettype wire
